// ==== hdl/pwmfc_pkg.sv ====
package pwmfc_pkg;
  // Default widths
  localparam int CNT_W_DEF  = 16;
  localparam int ADDR_W_DEF = 8;
  localparam int ST_W       = 3;

  // Word indices; byte address is index times four
  localparam logic [3:0] W_RUN  = 4'h0;
  localparam logic [3:0] W_IMSK = 4'h1;
  localparam logic [3:0] W_IREQ = 4'h2;
  localparam logic [3:0] W_ELC  = 4'h3;
  localparam logic [3:0] W_BUF  = 4'h4;
  localparam logic [3:0] W_PWM  = 4'h5;
  localparam logic [3:0] W_CUT  = 4'h6;
  localparam logic [3:0] W_OUTD = 4'h7;
  localparam logic [3:0] W_GRA  = 4'h8;
  localparam logic [3:0] W_STAT = 4'hc;
  localparam logic [3:0] W_EVM  = 4'hd;
  localparam logic [3:0] W_CNT  = 4'he;
  localparam logic [3:0] W_NONE = 4'hf;

  // Compare register slots
  localparam logic [1:0] GR_A = 2'h0;
  localparam logic [1:0] GR_B = 2'h1;
  localparam logic [1:0] GR_C = 2'h2;
  localparam logic [1:0] GR_D = 2'h3;

  // Field positions
  localparam int RUN_BIT  = 0;
  localparam int CONT_BIT = 2;
  localparam int IMSK_BIT = 1;
  localparam int IREQ_BIT = 1;
  localparam int ECUT_BIT = 1;
  localparam int BUFC_BIT = 4;
  localparam int BUFD_BIT = 5;
  localparam int PWMB_BIT = 0;
  localparam int CUTB_LO  = 4;
  localparam int CUTC_LO  = 2;
  localparam int CUTD_LO  = 0;
  localparam int ST_AM    = 0;
  localparam int ST_BM    = 1;
  localparam int ST_CUT   = 2;

  // Writable bits and reset values of the eight control bytes
  localparam logic [7:0] CTL_WMASK [0:7] = '{8'h05, 8'h02, 8'h02, 8'h02, 8'h30, 8'h01, 8'h3f, 8'h0f};
  localparam logic [7:0] CTL_RST   [0:7] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0f};
  localparam logic [ST_W-1:0] EVM_RST = 3'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Pin state under forced cutoff
  typedef enum logic [1:0] {
    PWMFC_CUT_OFF  = 2'b00,
    PWMFC_CUT_HIZ  = 2'b01,
    PWMFC_CUT_LOW  = 2'b10,
    PWMFC_CUT_HIGH = 2'b11
  } pwmfc_cut_e;
endpackage

// ==== hdl/pwmfc_pin_if.sv ====
interface pwmfc_pin_if;
  logic [3:0] lvl;   // Timer level per pin, A..D
  logic [7:0] mode;  // Cutoff mode, two bits per pin
  logic [3:0] dis;   // Output disable per pin
  logic       cut;   // Forced cutoff active
  logic [3:0] out;
  logic [3:0] oe;
  logic [3:0] port;

  modport core  (output lvl, mode, dis, cut, input out, oe, port);
  modport stage (input lvl, mode, dis, cut, output out, oe, port);
endinterface

// ==== hdl/pwmfc_outstage.sv ====
module pwmfc_outstage
  import pwmfc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic  i_clk,
  input  wire logic  i_arst_n,
  input  wire logic  i_ce,
  // Pin signals
  pwmfc_pin_if.stage pins
);
  logic [3:0] out_reg;
  logic [3:0] oe_reg;
  logic [3:0] port_reg;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pin
      pwmfc_cut_e m;
      logic       cut_on;
      logic       out_next;
      logic       oe_next;
      assign m        = pwmfc_cut_e'(pins.mode[2*g +: 2]);
      assign cut_on   = pins.cut && (m != PWMFC_CUT_OFF);
      // Disabled pin goes back to the port; cutoff overrides the timer level
      assign oe_next  = !pins.dis[g] && !(cut_on && m == PWMFC_CUT_HIZ);
      assign out_next = pins.dis[g] ? 1'b0 : cut_on ? (m == PWMFC_CUT_HIGH) : pins.lvl[g];
      // Registered so that pins never glitch on a mode change
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          out_reg[g]  <= 1'b0;
          oe_reg[g]   <= 1'b0;
          port_reg[g] <= 1'b1;
        end else if (i_ce) begin
          out_reg[g]  <= out_next;
          oe_reg[g]   <= oe_next;
          port_reg[g] <= pins.dis[g];
        end
      end
    end
  endgenerate

  assign pins.out  = out_reg;
  assign pins.oe   = oe_reg;
  assign pins.port = port_reg;
endmodule

// ==== hdl/pwmfc_core.sv ====
// Function
// RQ1: Continue bit 0 stops the counter at period match; 1 keeps it counting.
// RQ2: The counter advances only while the run flag is 1.
// RQ3: Channel mask bit 1 at one blocks the channel interrupt.
// RQ4: Request bit reads 1 while a request is pending; software clears it.
// RQ5: With event-cutoff enabled, an incoming event forces cutoff of pulse outputs.
// RQ6: D register buffers B when its select is 1, else is general.
// RQ7: C register buffers A when its select is 1, else is general.
// RQ8: Pin B select 1 gives PWM, 0 gives output compare.
// RQ9: Pin B cutoff mode: 0 none, 1 high impedance, 2 low, 3 high.
// RQ10: Pin C cutoff mode: 0 none, 1 high impedance, 2 low, 3 high.
// RQ11: Pin D cutoff mode: 0 none, 1 high impedance, 2 low, 3 high.
// RQ12: Pin D disable bit 1 hands the pin back to the port.
// RQ13: Pin C disable bit 1 hands the pin back to the port.
// RQ14: Pin B disable bit 1 hands the pin back to the port.
// RQ15: Pin A disable bit 1 hands the pin back to the port.
// RQ16: The event link controller routes the alarm event here as cutoff request.
// RQ17: Register A sets the PWM period; register B the B level change point.
// RQ18: Cutoff state holds until software restarts or reconfigures the channel.
module pwmfc_core
  import pwmfc_pkg::*;
#(
  parameter int CNT_W  = CNT_W_DEF,
  parameter int ADDR_W = ADDR_W_DEF
) (
  // Clock, reset, enable
  input  wire logic              I_CLK,
  input  wire logic              I_ARST_N,
  input  wire logic              I_CE,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] I_AWADDR,
  input  wire logic              I_AWVALID,
  output logic                   O_AWREADY,
  input  wire logic [31:0]       I_WDATA,
  input  wire logic [3:0]        I_WSTRB,
  input  wire logic              I_WVALID,
  output logic                   O_WREADY,
  output logic [1:0]             O_BRESP,
  output logic                   O_BVALID,
  input  wire logic              I_BREADY,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] I_ARADDR,
  input  wire logic              I_ARVALID,
  output logic                   O_ARREADY,
  output logic [31:0]            O_RDATA,
  output logic [1:0]             O_RRESP,
  output logic                   O_RVALID,
  input  wire logic              I_RREADY,
  // Event link
  input  wire logic              I_CUT_EVT,
  // Timer pins A..D
  output logic [3:0]             O_PIN_OUT,
  output logic [3:0]             O_PIN_OE,
  output logic [3:0]             O_PORT_SEL,
  // Interrupt
  output logic                   O_IRQ
);
  logic [7:0]        ctl_reg [0:7];
  logic [CNT_W-1:0]  gr_reg  [0:3];
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  cnt_next;
  logic [ST_W-1:0]   stat_reg;
  logic [ST_W-1:0]   stat_next;
  logic [ST_W-1:0]   evm_reg;
  logic              cut_reg;
  logic [3:0]        lvl_reg;
  logic [3:0]        lvl_next;
  logic              aw_got_reg;
  logic              w_got_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       rdata_reg;

  // Control fields
  logic       run;
  logic       cont;
  logic       chmask;
  logic       ireq;
  logic       ecut;
  logic       bufc;
  logic       bufd;
  logic       pwmb;
  logic [3:0] outdis;
  logic [5:0] cutm;
  assign run    = ctl_reg[W_RUN[2:0]][RUN_BIT];
  assign cont   = ctl_reg[W_RUN[2:0]][CONT_BIT];
  assign chmask = ctl_reg[W_IMSK[2:0]][IMSK_BIT];
  assign ireq   = ctl_reg[W_IREQ[2:0]][IREQ_BIT];
  assign ecut   = ctl_reg[W_ELC[2:0]][ECUT_BIT];
  assign bufc   = ctl_reg[W_BUF[2:0]][BUFC_BIT];
  assign bufd   = ctl_reg[W_BUF[2:0]][BUFD_BIT];
  assign pwmb   = ctl_reg[W_PWM[2:0]][PWMB_BIT];
  assign outdis = ctl_reg[W_OUTD[2:0]][3:0];
  assign cutm   = ctl_reg[W_CUT[2:0]][5:0];

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (s[k]) begin
        r[8*k +: 8] = d[8*k +: 8];
      end
    end
    return r;
  endfunction

  // Write decode; write fires once both address and data are held
  logic       wr_go;
  logic [3:0] w_idx;
  logic       w_hit;
  logic       wr_ok;
  logic       wr_ctl;
  logic       wr_run;
  logic       wr_cut;
  logic       wr_stat;
  logic       wr_evm;
  logic       wr_cnt;
  logic       wr_gr;
  assign wr_go   = I_CE && aw_got_reg && w_got_reg && !bvalid_reg;
  assign w_idx   = awaddr_reg[5:2];
  assign w_hit   = (awaddr_reg[ADDR_W-1:6] == '0) && (w_idx != W_NONE) && (w_idx[3:2] != 2'b11 || w_idx < W_NONE);
  assign wr_ok   = wr_go && w_hit;
  assign wr_ctl  = wr_ok && !w_idx[3] && wstrb_reg[0];
  assign wr_run  = wr_ctl && (w_idx == W_RUN);
  assign wr_cut  = wr_ctl && (w_idx == W_CUT);
  assign wr_stat = wr_ok && (w_idx == W_STAT) && wstrb_reg[0];
  assign wr_evm  = wr_ok && (w_idx == W_EVM) && wstrb_reg[0];
  assign wr_cnt  = wr_ok && (w_idx == W_CNT);
  assign wr_gr   = wr_ok && (w_idx[3:2] == 2'b10);

  // Handshakes; a low clock enable stalls the bus as well
  assign O_AWREADY = I_CE && !aw_got_reg && !bvalid_reg;
  assign O_WREADY  = I_CE && !w_got_reg && !bvalid_reg;
  assign O_ARREADY = I_CE && !rvalid_reg;
  assign O_BVALID  = bvalid_reg;
  assign O_BRESP   = bresp_reg;
  assign O_RVALID  = rvalid_reg;
  assign O_RRESP   = rresp_reg;
  assign O_RDATA   = rdata_reg;

  // Write channel capture and response
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg  <= 32'h0;
      wstrb_reg  <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (I_CE) begin
      if (O_AWREADY && I_AWVALID) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= I_AWADDR;
      end
      if (O_WREADY && I_WVALID) begin
        w_got_reg <= 1'b1;
        wdata_reg <= I_WDATA;
        wstrb_reg <= I_WSTRB;
      end
      if (wr_go) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg  <= w_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && I_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read decode
  logic [3:0]  r_idx;
  logic        r_hit;
  logic [31:0] rd_word;
  assign r_idx   = I_ARADDR[5:2];
  assign r_hit   = (I_ARADDR[ADDR_W-1:6] == '0) && (r_idx != W_NONE);
  assign rd_word = !r_hit ? 32'h0 :
                   !r_idx[3] ? {24'h0, ctl_reg[r_idx[2:0]]} :
                   (r_idx[3:2] == 2'b10) ? 32'(gr_reg[r_idx[1:0]]) :
                   (r_idx == W_STAT) ? 32'(stat_reg) :
                   (r_idx == W_EVM) ? 32'(evm_reg) : 32'(cnt_reg);

  // Read answer one cycle after the address is taken
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h0;
    end else if (I_CE) begin
      if (O_ARREADY && I_ARVALID) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= r_hit ? RESP_OKAY : RESP_SLVERR;
        rdata_reg  <= rd_word;
      end else if (rvalid_reg && I_RREADY) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Compare matches are only seen while counting
  logic a_match;
  logic b_match;
  logic c_match;
  logic d_match;
  logic stop_hit;
  logic cut_set;
  logic cut_clr;
  assign a_match  = run && (cnt_reg == gr_reg[GR_A]); // RQ17
  assign b_match  = run && (cnt_reg == gr_reg[GR_B]); // RQ17
  assign c_match  = run && (cnt_reg == gr_reg[GR_C]);
  assign d_match  = run && (cnt_reg == gr_reg[GR_D]);
  assign stop_hit = a_match && !cont; // RQ1
  assign cut_set  = I_CUT_EVT && ecut; // RQ5 RQ16
  assign cut_clr  = (wr_run && wdata_reg[RUN_BIT]) || wr_cut; // RQ18

  // Counter: software write wins, A match clears, otherwise count while run
  assign cnt_next = wr_cnt ? CNT_W'(merge(32'(cnt_reg), wdata_reg, wstrb_reg)) :
                    a_match ? '0 :
                    run ? CNT_W'(cnt_reg + 1'b1) : cnt_reg; // RQ2

  // Pin levels: A toggles on period match, B is PWM or compare toggle
  assign lvl_next[0] = lvl_reg[0] ^ a_match;
  assign lvl_next[1] = pwmb ? (a_match ? 1'b0 : (b_match ? 1'b1 : lvl_reg[1])) : lvl_reg[1] ^ b_match; // RQ8
  assign lvl_next[2] = lvl_reg[2] ^ (c_match && !bufc);
  assign lvl_next[3] = lvl_reg[3] ^ (d_match && !bufd);

  // Sticky events: set wins over the write-one clear
  logic [ST_W-1:0] st_set;
  assign st_set    = {cut_set, b_match, a_match};
  assign stat_next = (stat_reg & ~(wr_stat ? wdata_reg[ST_W-1:0] : '0)) | st_set;

  // Timer state
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cnt_reg  <= '0;
      lvl_reg  <= 4'h0;
      stat_reg <= '0;
      evm_reg  <= EVM_RST;
      cut_reg  <= 1'b0;
    end else if (I_CE) begin
      cnt_reg  <= cnt_next;
      lvl_reg  <= lvl_next;
      stat_reg <= stat_next;
      if (wr_evm) begin
        evm_reg <= wdata_reg[ST_W-1:0];
      end
      cut_reg <= cut_set || (cut_reg && !cut_clr); // RQ5 RQ18
    end
  end

  // Compare registers with buffer transfer at the period boundary
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      for (int k = 0; k < 4; k++) begin
        gr_reg[k] <= '0;
      end
    end else if (I_CE) begin
      if (wr_gr) begin
        gr_reg[w_idx[1:0]] <= CNT_W'(merge(32'(gr_reg[w_idx[1:0]]), wdata_reg, wstrb_reg));
      end
      if (a_match && bufc && !(wr_gr && w_idx[1:0] == GR_A)) begin
        gr_reg[GR_A] <= gr_reg[GR_C]; // RQ7
      end
      if (a_match && bufd && !(wr_gr && w_idx[1:0] == GR_B)) begin
        gr_reg[GR_B] <= gr_reg[GR_D]; // RQ6
      end
    end
  end

  // Control bytes; the pending request is set by any unmasked event
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      for (int k = 0; k < 8; k++) begin
        ctl_reg[k] <= CTL_RST[k];
      end
    end else if (I_CE) begin
      if (wr_ctl) begin
        ctl_reg[w_idx[2:0]] <= wdata_reg[7:0] & CTL_WMASK[w_idx[2:0]];
      end
      if (stop_hit && !wr_run) begin
        ctl_reg[W_RUN[2:0]][RUN_BIT] <= 1'b0; // RQ1
      end
      if (|(st_set & ~evm_reg)) begin
        ctl_reg[W_IREQ[2:0]][IREQ_BIT] <= 1'b1; // RQ4
      end
    end
  end

  // Interrupt is a level while an unmasked event is held
  assign O_IRQ = |(stat_reg & ~evm_reg) && !chmask; // RQ3

  // Output stage
  pwmfc_pin_if pins ();
  assign pins.lvl  = lvl_reg;
  assign pins.mode = {cutm[CUTD_LO +: 2], cutm[CUTC_LO +: 2], cutm[CUTB_LO +: 2], 2'b00}; // RQ9 RQ10 RQ11
  assign pins.dis  = outdis; // RQ12 RQ13 RQ14 RQ15
  assign pins.cut  = cut_reg;

  pwmfc_outstage u_stage (
    .i_clk    (I_CLK),
    .i_arst_n (I_ARST_N),
    .i_ce     (I_CE),
    .pins     (pins.stage)
  );

  assign O_PIN_OUT  = pins.out;
  assign O_PIN_OE   = pins.oe;
  assign O_PORT_SEL = pins.port;

  // Checks
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_ARST_N);

  sequence s_cut_mode(int lo, logic [1:0] m, int p);
    I_CE && cut_reg && cutm[lo +: 2] == m && !outdis[p];
  endsequence

  period_stop_a: assert property (I_CE && stop_hit && !wr_run |=> !run) // RQ1
    else $error("counter did not stop at period match");
  count_hold_a: assert property (I_CE && !run && !wr_cnt |=> cnt_reg == $past(cnt_reg)) // RQ2
    else $error("counter moved while stopped");
  irq_mask_a: assert property (chmask |-> !O_IRQ) // RQ3
    else $error("masked interrupt reached output");
  irq_request_a: assert property (I_CE && run && a_match && !evm_reg[ST_AM] |=> ireq && stat_reg[ST_AM]) // RQ4
    else $error("request not pending after event");
  cut_trigger_a: assert property (I_CE && I_CUT_EVT && ecut |=> cut_reg ##1 (I_CE || cut_reg)) // RQ5
    else $error("enabled event did not force cutoff");
  cut_ignore_a: assert property (I_CE && !cut_reg && !(I_CUT_EVT && ecut) |=> !cut_reg) // RQ5
    else $error("cutoff without enabled event");
  buf_c_a: assert property (I_CE && a_match && bufc && !wr_gr |=> gr_reg[GR_A] == $past(gr_reg[GR_C])) // RQ7
    else $error("C buffer not moved into A");
  buf_d_a: assert property (I_CE && a_match && bufd && !wr_gr |=> gr_reg[GR_B] == $past(gr_reg[GR_D])) // RQ6
    else $error("D buffer not moved into B");
  cut_hold_a: assert property (I_CE && cut_reg && !cut_clr |=> cut_reg) // RQ18
    else $error("cutoff released without software");
  pin_b_low_a: assert property (s_cut_mode(CUTB_LO, 2'b10, 1) |=> O_PIN_OE[1] && !O_PIN_OUT[1]) // RQ9
    else $error("pin B not driven low in cutoff");
  pin_c_hiz_a: assert property (s_cut_mode(CUTC_LO, 2'b01, 2) |=> !O_PIN_OE[2] && !O_PORT_SEL[2]) // RQ10
    else $error("pin C not released in cutoff");
  pin_d_high_a: assert property (s_cut_mode(CUTD_LO, 2'b11, 3) |=> O_PIN_OE[3] && O_PIN_OUT[3]) // RQ11
    else $error("pin D not driven high in cutoff");
  pin_disable_a: assert property (I_CE && outdis[0] |=> O_PORT_SEL[0] && !O_PIN_OE[0]) // RQ15
    else $error("disabled pin A still driven");
  pwm_b_a: assert property (I_CE && pwmb && b_match && !a_match && !cut_reg && !cut_set // RQ8
                            && !outdis[1] && !wr_ctl ##1 I_CE |=> O_PIN_OUT[1])
    else $error("PWM B did not change level at match");
endmodule

// ==== testbench/pwmfc_evlink_model.sv ====
module pwmfc_evlink_model (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  // Request from the bench
  input  wire logic i_fire,
  input  wire logic i_slow,
  // Event toward the channel
  output logic      o_evt
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] wait_reg;
  logic       busy_reg;

  // Forward an alarm as a one-cycle pulse, at once or three cycles late
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_evt    <= 1'b0;
      busy_reg <= 1'b0;
      wait_reg <= 2'h0;
    end else begin
      o_evt <= 1'b0;
      if (i_fire && !i_slow) begin
        o_evt <= 1'b1;
      end else if (i_fire) begin
        busy_reg <= 1'b1;
        wait_reg <= 2'h2;
      end else if (busy_reg) begin
        wait_reg <= wait_reg - 2'h1;
        if (wait_reg == 2'h0) begin
          busy_reg <= 1'b0;
          o_evt    <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== testbench/testbench.sv ====
module testbench
  import pwmfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, arst_n, ce, fire, slow, evt, irq;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, pin_out, pin_oe, port_sel;
  logic [1:0]  bresp, rresp;
  int          fails, num_checks;

  // Design and event source
  pwmfc_core pwmfc_core_inst (.I_CLK(clk), .I_ARST_N(arst_n), .I_CE(ce), .I_AWADDR(awaddr),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
    .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
    .I_RREADY(rready), .I_CUT_EVT(evt), .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe),
    .O_PORT_SEL(port_sel), .O_IRQ(irq));
  pwmfc_evlink_model pwmfc_evlink_model_inst (.i_clk(clk), .i_arst_n(arst_n), .i_fire(fire),
    .i_slow(slow), .o_evt(evt));

  always #5 clk = ~clk;

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic give_up();
    fails++;
    $display("unexpected at %0t: wait ran out", $time);
    complete_run();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // Readies are sampled at the falling edge so the taking edge is known without a race
  task automatic wr(input logic [3:0] idx, input logic [31:0] data, output logic [1:0] resp);
    logic aw_go, w_go, b_go;
    int   n;
    @(posedge clk);
    awaddr  <= {2'b00, idx, 2'b00};
    wdata   <= data;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge clk);
      aw_go = awvalid && awready;
      w_go  = wvalid && wready;
      b_go  = bvalid;
      resp  = bresp;
      @(posedge clk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
      if (b_go) begin
        bready <= 1'b0;
        return;
      end
    end
    give_up();
  endtask

  task automatic rd(input logic [3:0] idx, output logic [31:0] data, output logic [1:0] resp);
    logic ar_go, r_go;
    int   n;
    @(posedge clk);
    araddr  <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge clk);
      ar_go = arvalid && arready;
      r_go  = rvalid;
      data  = rdata;
      resp  = rresp;
      @(posedge clk);
      if (ar_go) arvalid <= 1'b0;
      if (r_go) begin
        rready <= 1'b0;
        return;
      end
    end
    give_up();
  endtask

  task automatic put(input logic [3:0] idx, input logic [31:0] data);
    logic [1:0] r;
    wr(idx, data, r);
    check(r, RESP_OKAY);
  endtask

  task automatic expect_reg(input logic [3:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(idx, d, r);
    check(d, exp);
  endtask

  task automatic fire_evt(input logic late);
    @(posedge clk);
    fire <= 1'b1;
    slow <= late;
    @(posedge clk);
    fire <= 1'b0;
  endtask

  // Length of the next complete level on one pin, in cycles
  task automatic span(input int idx, output int len, output logic lvl);
    logic prev;
    int   n;
    @(negedge clk);
    prev = pin_out[idx];
    for (n = 0; n < 100 && pin_out[idx] === prev; n++) @(negedge clk);
    lvl = pin_out[idx];
    for (len = 0; len < 100 && pin_out[idx] === lvl; len++) @(negedge clk);
    if (n == 100 || len == 100) give_up();
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 8; i++) begin
      rd(i[3:0], d, r);
      check(d, {24'h0, CTL_RST[i]});
    end
    check(port_sel, 4'hf);
    check(pin_oe, 4'h0);
    rd(W_NONE, d, r);
    check(r, RESP_SLVERR);
    check(d, 32'h0);
  endtask

  task automatic t_run();
    logic [31:0] c;
    logic [31:0] c1;
    logic [31:0] c2;
    logic [1:0]  r;
    put(W_GRA, 32'hffff);
    put(W_RUN, 32'h5);
    rd(W_CNT, c, r);
    check(c > 32'h0, 1'b1);
    // Eleven extra edges before the third read, ten of them frozen: one step more than the first gap
    rd(W_CNT, c1, r);
    rd(W_CNT, c2, r);
    @(posedge clk);
    ce <= 1'b0;
    repeat (10) @(posedge clk);
    check(arready, 1'b0);
    ce <= 1'b1;
    rd(W_CNT, c, r);
    check(c - c2, c2 - c1 + 32'h1);
    put(W_RUN, 32'h4);
    put(W_CNT, 32'h10);
    repeat (10) @(posedge clk);
    expect_reg(W_CNT, 32'h10);
    put(W_GRA, 32'h5);
    put(W_CNT, 32'h0);
    put(W_RUN, 32'h1);
    repeat (20) @(posedge clk);
    expect_reg(W_RUN, 32'h0);
    expect_reg(W_CNT, 32'h0);
    put(W_RUN, 32'h5);
    repeat (20) @(posedge clk);
    expect_reg(W_RUN, 32'h5);
    put(W_RUN, 32'h0);
  endtask

  // Only the period match is left unmasked, so one stop-at-match raises the line
  task automatic t_irq();
    put(W_STAT, 32'h7);
    put(W_IREQ, 32'h0);
    put(W_EVM, 32'h6);
    put(W_IMSK, 32'h0);
    put(W_CNT, 32'h0);
    put(W_GRA, 32'h4);
    put(W_RUN, 32'h1);
    repeat (20) @(posedge clk);
    check(irq, 1'b1);
    expect_reg(W_IREQ, 32'h2);
    put(W_IMSK, 32'h2);
    check(irq, 1'b0);
    put(W_IREQ, 32'h0);
    expect_reg(W_IREQ, 32'h0);
    put(W_IMSK, 32'h0);
    put(W_STAT, 32'h1);
    check(irq, 1'b0);
  endtask

  task automatic t_cut();
    logic [1:0] m;
    put(W_OUTD, 32'h0);
    put(W_ELC, 32'h0);
    put(W_CUT, 32'h15);
    fire_evt(1'b0);
    repeat (4) @(posedge clk);
    check(pin_oe, 4'hf);
    put(W_ELC, 32'h2);
    for (int k = 0; k < 4; k++) begin
      m = k[1:0];
      put(W_CUT, {26'h0, m, m, m});
      fire_evt(k == 2);
      repeat (6) @(posedge clk);
      check(pin_oe[1], m != 2'h1);
      check(pin_oe[2], m != 2'h1);
      check(pin_oe[3], m != 2'h1);
      if (m[1]) check(pin_out[3:1], m[0] ? 3'h7 : 3'h0);
    end
    repeat (30) @(posedge clk);
    check(pin_out[3:1], 3'h7);
    put(W_RUN, 32'h1);
    repeat (3) @(posedge clk);
    check(pin_oe, 4'hf);
    put(W_RUN, 32'h0);
  endtask

  task automatic t_dis();
    logic [3:0] sel, en;
    for (int i = 0; i < 4; i++) begin
      sel = 4'h1 << i;
      en  = ~sel;
      put(W_OUTD, {28'h0, sel});
      repeat (3) @(posedge clk);
      check(port_sel, sel);
      check(pin_oe, en);
    end
    put(W_OUTD, 32'h2);
    repeat (3) @(posedge clk);
    check(pin_oe, 4'hd);
  endtask

  // Period 10 cycles, level change at count 3: high 6, low 4
  task automatic t_pwm();
    int   len;
    logic lvl;
    put(W_OUTD, 32'h0);
    put(W_CNT, 32'h0);
    put(W_GRA, 32'h9);
    put(W_GRA + 4'h1, 32'h3);
    put(W_PWM, 32'h1);
    put(W_RUN, 32'h5);
    for (int k = 0; k < 2; k++) begin
      span(1, len, lvl);
      check(len, lvl ? 6 : 4);
    end
    put(W_PWM, 32'h0);
    span(1, len, lvl);
    span(1, len, lvl);
    check(len, 10);
    span(0, len, lvl);
    check(len, 10);
    put(W_RUN, 32'h0);
  endtask

  task automatic t_buf();
    put(W_CNT, 32'h0);
    put(W_GRA + 4'h2, 32'h7);
    put(W_GRA + 4'h3, 32'h2);
    put(W_BUF, 32'hffffffff);
    expect_reg(W_BUF, 32'h30);
    put(W_RUN, 32'h5);
    repeat (30) @(posedge clk);
    put(W_RUN, 32'h0);
    expect_reg(W_GRA, 32'h7);
    expect_reg(W_GRA + 4'h1, 32'h2);
    put(W_BUF, 32'h0);
    put(W_GRA + 4'h2, 32'h5);
    put(W_GRA + 4'h3, 32'h1);
    put(W_RUN, 32'h5);
    repeat (30) @(posedge clk);
    put(W_RUN, 32'h0);
    expect_reg(W_GRA, 32'h7);
    expect_reg(W_GRA + 4'h1, 32'h2);
  endtask

  // Main sequence; reset is held for twenty cycles
  initial begin
    {clk, arst_n, fire, slow, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    ce         = 1'b1;
    wstrb      = 4'hf;
    fails      = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_run();
    t_irq();
    t_cut();
    t_dis();
    t_pwm();
    t_buf();
    complete_run();
  end
endmodule
